// *** src/swrt_seq.v ***
// sequencer slot engine with gate wait, reset release timer
// and buck current limit decode, all behind an APB slave
// assumes inputs merge_mode, full_current_mode, reset_output_mode
// come from logic on ref_clk; pins are synchronised here
//
// Notes on behaviour
// - output pin a rises at its low slot, falls at its high slot.
// - output pin b rises at its low slot, falls at its high slot.
// - progress holds at the gate slot, on gating input or delay timer.
// - system and power end pointers end the respective up sequences.
// - partial power-down stops at the partial shutdown slot.
// - final pointer is the highest slot counted to.
// - two-bit direction chooses never, up only, down only, both.
// - timeout bit ends an input wait after 500 ms.
// - wait kind bit picks gating input or delay timer.
// - four-bit code sets timer wait, 512 us doubling to 8.4 s.
// - two-bit field picks the event starting the reset timer.
// - release time in 1.024 ms steps, then 32.768 ms steps.
// - memory buck limit 1500 mA plus 100 mA steps, doubled merged.
// - io and peripheral buck limits 1500 mA to 3000 mA.
// - processor buck limit 500 mA plus 100 mA steps, doubled at full current.
// - current slot pointer is readable and compared to slot fields.
// - each slot lasts the time chosen by the duration code.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "swrt_seq_defines.vh"

module swrt_seq #(
    parameter TICK_CYCLES = `SWRT_TICK_CYCLES
) (
    input wire ref_clk,
    input wire resetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire gating_input,
    input wire outside_wakeup,
    input wire merge_mode,
    input wire full_current_mode,
    input wire reset_output_mode,
    output reg output_pin_a,
    output reg output_pin_b,
    output reg system_domain_up,
    output reg power_domain_up,
    output reg reset_release,
    output reg seq_busy,
    output reg [3:0] current_slot,
    output reg [12:0] mem_buck_limit,
    output reg [12:0] io_buck_limit,
    output reg [12:0] peripheral_buck_limit,
    output reg [12:0] processor_buck_limit
);

// *****************************
// states and functions
// *****************************
localparam S_IDLE = 3'b001;
localparam S_RUN = 3'b010;
localparam S_WAIT = 3'b100;
// slot duration in microseconds
function [23:0] slot_us;
    input [3:0] code;
    begin
        case (code)
            4'h9: slot_us = 24'd384;
            4'ha: slot_us = 24'd448;
            4'hb: slot_us = 24'd512;
            4'hc: slot_us = 24'd1024;
            4'hd: slot_us = 24'd2048;
            4'he: slot_us = 24'd4096;
            4'hf: slot_us = 24'd8192;
            default: slot_us = {15'h0, code + 5'h1, 4'h0} << 1;
        endcase
    end
endfunction
// delay-timer wait in microseconds
function [23:0] wait_us;
    input [3:0] code;
    begin
        if (code == 4'h0) begin
            wait_us = 24'h0;
        end else begin
            wait_us = 24'd512 << (code - 4'h1);
        end
    end
endfunction
// release time in microseconds
function [20:0] release_us;
    input [5:0] code;
    begin
        if (code <= 6'd32) begin
            release_us = {15'h0, code} * 21'd`SWRT_REL_STEP_US;
        end else begin
            release_us = {15'h0, code - 6'd31} * 21'd`SWRT_REL_BIG_US;
        end
    end
endfunction
// 1500 mA base limit
function [12:0] hi_lim;
    input [3:0] code;
    begin
        hi_lim = 13'd`SWRT_LIM_BASE_MA + {9'h0, code} * 13'd100;
    end
endfunction

// *****************************
// declarations
// *****************************
reg [7:0] slot_time_reg, out_a_reg, out_b_reg, gate_reg, domain_reg;
reg [7:0] partial_reg, hold_reg, release_reg, lim_a_reg, lim_b_reg;
reg [5:0] ctrl_reg;
reg [2:0] state_reg;
reg dir_down_reg, enter_reg, waited_reg, us_tick_reg, boot_reg, rel_run_reg;
reg gate_s1_reg, gate_s2_reg, wake_s1_reg, wake_s2_reg, wake_d_reg;
reg [3:0] end_reg, up_end;
reg [23:0] timer_reg;
reg [7:0] tick_cnt_reg;
reg [20:0] rel_cnt_reg;
reg [31:0] rd_next;
reg hit, up_cmd, down_cmd, trig, gate_here;
wire [7:0] idx = paddr[9:2];
wire aligned = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
wire wr_go = psel && penable && pready && pwrite && !pslverr;
// *****************************
// apb slave: one wait state, errors on unmapped words
// *****************************
always @* begin
    rd_next = 32'h0;
    hit = aligned;
    case (idx)
        `SWRT_IDX_SLOT: rd_next[3:0] = current_slot;
        `SWRT_IDX_SLOT_TIME: rd_next[7:0] = slot_time_reg;
        `SWRT_IDX_OUT_A: rd_next[7:0] = out_a_reg;
        `SWRT_IDX_OUT_B: rd_next[7:0] = out_b_reg;
        `SWRT_IDX_GATE: rd_next[7:0] = gate_reg;
        `SWRT_IDX_DOMAIN: rd_next[7:0] = domain_reg;
        `SWRT_IDX_PARTIAL: rd_next[7:0] = partial_reg;
        `SWRT_IDX_HOLD: rd_next[7:0] = hold_reg;
        `SWRT_IDX_SPARE: rd_next = 32'h0;
        `SWRT_IDX_RELEASE: rd_next[7:0] = release_reg;
        `SWRT_IDX_LIM_A: rd_next[7:0] = lim_a_reg;
        `SWRT_IDX_LIM_B: rd_next[7:0] = lim_b_reg;
        `SWRT_IDX_CTRL: rd_next[7:0] = {1'b0, reset_release,
            power_domain_up, system_domain_up, state_reg == S_WAIT,
            dir_down_reg, ctrl_reg[`SWRT_CTRL_PART], seq_busy};
        default: hit = 1'b0;
    endcase
end
always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h0;
    end else begin
        pready <= psel && penable && !pready;
        pslverr <= psel && penable && !pready && !hit;
        if (psel && penable && !pready) begin
            prdata <= pwrite ? 32'h0 : rd_next;
        end
    end
end
always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        slot_time_reg <= `SWRT_REG_RST;
        out_a_reg <= `SWRT_REG_RST;
        out_b_reg <= `SWRT_REG_RST;
        gate_reg <= `SWRT_REG_RST;
        domain_reg <= `SWRT_REG_RST;
        partial_reg <= `SWRT_REG_RST;
        hold_reg <= `SWRT_REG_RST;
        release_reg <= `SWRT_REG_RST;
        lim_a_reg <= `SWRT_REG_RST;
        lim_b_reg <= `SWRT_REG_RST;
        ctrl_reg <= 6'h0;
    end else begin
        if (wr_go) begin
            case (idx)
                `SWRT_IDX_SLOT_TIME: slot_time_reg <= pwdata[7:0];
                `SWRT_IDX_OUT_A: out_a_reg <= pwdata[7:0];
                `SWRT_IDX_OUT_B: out_b_reg <= pwdata[7:0];
                `SWRT_IDX_GATE: gate_reg <= pwdata[7:0];
                `SWRT_IDX_DOMAIN: domain_reg <= pwdata[7:0];
                `SWRT_IDX_PARTIAL: partial_reg <= pwdata[7:0];
                `SWRT_IDX_HOLD: hold_reg <= pwdata[7:0];
                `SWRT_IDX_RELEASE: release_reg <= pwdata[7:0];
                `SWRT_IDX_LIM_A: lim_a_reg <= pwdata[7:0];
                `SWRT_IDX_LIM_B: lim_b_reg <= pwdata[7:0];
                `SWRT_IDX_CTRL: ctrl_reg <= pwdata[5:0];
                default: ctrl_reg <= ctrl_reg;
            endcase
        end
    end
end
// start commands are pulses taken only while idle
always @* begin
    up_cmd = wr_go && (idx == `SWRT_IDX_CTRL) && pwdata[`SWRT_CTRL_UP]
        && (state_reg == S_IDLE);
    down_cmd = wr_go && (idx == `SWRT_IDX_CTRL) && !pwdata[`SWRT_CTRL_UP]
        && pwdata[`SWRT_CTRL_DOWN] && (state_reg == S_IDLE);
    case (pwdata[`SWRT_CTRL_TGT])
        2'h0: up_end = domain_reg[`SWRT_LO_NIB];
        2'h1: up_end = domain_reg[`SWRT_HI_NIB];
        default: up_end = partial_reg[`SWRT_LO_NIB];
    endcase
    gate_here = (current_slot == gate_reg[`SWRT_LO_NIB]) && !waited_reg &&
        (dir_down_reg ? hold_reg[7] : hold_reg[6]);
end

// *****************************
// microsecond timebase and pin synchronisers
// *****************************
always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        tick_cnt_reg <= 8'h0;
        us_tick_reg <= 1'b0;
        gate_s1_reg <= 1'b0;
        gate_s2_reg <= 1'b0;
        wake_s1_reg <= 1'b0;
        wake_s2_reg <= 1'b0;
        wake_d_reg <= 1'b0;
    end else begin
        us_tick_reg <= (tick_cnt_reg == TICK_CYCLES - 1);
        if (tick_cnt_reg == TICK_CYCLES - 1) begin
            tick_cnt_reg <= 8'h0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 8'h1;
        end
        gate_s1_reg <= gating_input;
        gate_s2_reg <= gate_s1_reg;
        wake_s1_reg <= outside_wakeup;
        wake_s2_reg <= wake_s1_reg;
        wake_d_reg <= wake_s2_reg;
    end
end

// *****************************
// slot sequencer
// *****************************
always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        state_reg <= S_IDLE;
        dir_down_reg <= 1'b0;
        enter_reg <= 1'b0;
        waited_reg <= 1'b0;
        end_reg <= 4'h0;
        timer_reg <= 24'h0;
        current_slot <= 4'h0;
        seq_busy <= 1'b0;
        output_pin_a <= 1'b0;
        output_pin_b <= 1'b0;
        system_domain_up <= 1'b0;
        power_domain_up <= 1'b0;
    end else begin
        enter_reg <= 1'b0;
        if (enter_reg) begin
            timer_reg <= slot_us(slot_time_reg[`SWRT_LO_NIB]);
            waited_reg <= 1'b0;
            if (!dir_down_reg) begin
                if (current_slot == out_a_reg[`SWRT_LO_NIB]) begin
                    output_pin_a <= 1'b1;
                end
                if (current_slot == out_b_reg[`SWRT_LO_NIB]) begin
                    output_pin_b <= 1'b1;
                end
            end else begin
                if (current_slot == out_a_reg[`SWRT_HI_NIB]) begin
                    output_pin_a <= 1'b0;
                end
                if (current_slot == out_b_reg[`SWRT_HI_NIB]) begin
                    output_pin_b <= 1'b0;
                end
            end
            if (current_slot == domain_reg[`SWRT_LO_NIB]) begin
                system_domain_up <= !dir_down_reg;
            end
            if (current_slot == domain_reg[`SWRT_HI_NIB]) begin
                power_domain_up <= !dir_down_reg;
            end
        end
        case (state_reg)
            S_IDLE: begin
                seq_busy <= up_cmd || down_cmd;
                if (up_cmd || down_cmd) begin
                    dir_down_reg <= down_cmd;
                    end_reg <= down_cmd ? (pwdata[`SWRT_CTRL_PART] ?
                        partial_reg[`SWRT_HI_NIB] : 4'h0) : up_end;
                    enter_reg <= 1'b1;
                    state_reg <= S_RUN;
                end
            end
            S_RUN: begin
                if (!enter_reg && timer_reg == 24'h0) begin
                    if (gate_here) begin
                        waited_reg <= 1'b1;
                        state_reg <= S_WAIT;
                        timer_reg <= hold_reg[`SWRT_MODE_BIT] ?
                            wait_us(hold_reg[`SWRT_LO_NIB]) :
                            `SWRT_TIMEOUT_US;
                    end else if (current_slot == end_reg ||
                        (!dir_down_reg && current_slot == 4'hf) ||
                        (dir_down_reg && current_slot == 4'h0)) begin
                        state_reg <= S_IDLE;
                        seq_busy <= 1'b0;
                    end else begin
                        current_slot <= dir_down_reg ?
                            current_slot - 4'h1 : current_slot + 4'h1;
                        enter_reg <= 1'b1;
                    end
                end else if (!enter_reg && us_tick_reg) begin
                    timer_reg <= timer_reg - 24'h1;
                end
            end
            S_WAIT: begin
                if (hold_reg[`SWRT_MODE_BIT] ? timer_reg == 24'h0 :
                    (gate_s2_reg || (hold_reg[`SWRT_TOUT_BIT] &&
                    timer_reg == 24'h0))) begin
                    state_reg <= S_RUN;
                    timer_reg <= 24'h0;
                end else if (us_tick_reg && timer_reg != 24'h0) begin
                    timer_reg <= timer_reg - 24'h1;
                end
            end
            default: begin
                state_reg <= S_IDLE;
                seq_busy <= 1'b0;
            end
        endcase
    end
end

// *****************************
// reset release timer
// *****************************
always @* begin
    case (release_reg[`SWRT_TRIG_F])
        `SWRT_TRIG_WAKE: trig = wake_s2_reg && !wake_d_reg;
        `SWRT_TRIG_SYS: trig = enter_reg && !dir_down_reg &&
            current_slot == domain_reg[`SWRT_LO_NIB];
        `SWRT_TRIG_PWR: trig = enter_reg && !dir_down_reg &&
            current_slot == domain_reg[`SWRT_HI_NIB];
        default: trig = boot_reg && !reset_output_mode;
    endcase
end
always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        boot_reg <= 1'b1;
        rel_run_reg <= 1'b0;
        rel_cnt_reg <= 21'h0;
        reset_release <= 1'b0;
    end else begin
        boot_reg <= 1'b0;
        if (down_cmd) begin
            rel_run_reg <= 1'b0;
            reset_release <= 1'b0;
        end else if (trig) begin
            rel_run_reg <= 1'b1;
            rel_cnt_reg <= release_us(release_reg[`SWRT_RTIME_F]);
        end else if (rel_run_reg) begin
            if (rel_cnt_reg == 21'h0) begin
                rel_run_reg <= 1'b0;
                reset_release <= 1'b1;
            end else if (us_tick_reg) begin
                rel_cnt_reg <= rel_cnt_reg - 21'h1;
            end
        end
    end
end

// *****************************
// buck current limits in mA
// *****************************
always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        mem_buck_limit <= 13'h0;
        io_buck_limit <= 13'h0;
        peripheral_buck_limit <= 13'h0;
        processor_buck_limit <= 13'h0;
    end else begin
        mem_buck_limit <= hi_lim(lim_a_reg[`SWRT_HI_NIB]) <<
            merge_mode;
        io_buck_limit <= hi_lim(lim_a_reg[`SWRT_LO_NIB]);
        peripheral_buck_limit <= hi_lim(lim_b_reg[`SWRT_HI_NIB]);
        processor_buck_limit <= (13'd`SWRT_PRO_BASE_MA +
            {9'h0, lim_b_reg[`SWRT_LO_NIB]} * 13'd100) <<
            full_current_mode;
    end
end

endmodule // swrt_seq

// *** src/swrt_seq_defines.vh ***
// constants for the sequencer wait and reset timing block
// assumes a 200 MHz clock and word-aligned APB registers
`ifndef SWRT_SEQ_DEFINES_VH
`define SWRT_SEQ_DEFINES_VH
// *****************************
// register indices, byte address is four times the index
// *****************************
`define SWRT_IDX_SLOT 8'h81
`define SWRT_IDX_SLOT_TIME 8'h82
`define SWRT_IDX_OUT_A 8'h90
`define SWRT_IDX_OUT_B 8'h91
`define SWRT_IDX_GATE 8'h92
`define SWRT_IDX_DOMAIN 8'h95
`define SWRT_IDX_PARTIAL 8'h96
`define SWRT_IDX_HOLD 8'h97
`define SWRT_IDX_SPARE 8'h98
`define SWRT_IDX_RELEASE 8'h99
`define SWRT_IDX_LIM_A 8'h9a
`define SWRT_IDX_LIM_B 8'h9b
`define SWRT_IDX_CTRL 8'ha0
// *****************************
// field positions
// *****************************
`define SWRT_HI_NIB 7:4
`define SWRT_LO_NIB 3:0
`define SWRT_DIR_F 7:6
`define SWRT_TOUT_BIT 5
`define SWRT_MODE_BIT 4
`define SWRT_TRIG_F 7:6
`define SWRT_RTIME_F 5:0
`define SWRT_CTRL_UP 0
`define SWRT_CTRL_DOWN 1
`define SWRT_CTRL_PART 2
`define SWRT_CTRL_TGT 5:4
// *****************************
// reset values and encodings
// *****************************
`define SWRT_REG_RST 8'h00
`define SWRT_TRIG_WAKE 2'h0
`define SWRT_TRIG_SYS 2'h1
`define SWRT_TRIG_PWR 2'h2
`define SWRT_TRIG_BOOT 2'h3
// *****************************
// timing
// *****************************
`define SWRT_CLK_MHZ 200
`define SWRT_TICK_CYCLES (`SWRT_CLK_MHZ)
`define SWRT_TIMEOUT_MS 500
`define SWRT_TIMEOUT_US 24'd500000
`define SWRT_REL_STEP_US 1024
`define SWRT_REL_BIG_US 32768
`define SWRT_LIM_BASE_MA 1500
`define SWRT_PRO_BASE_MA 500
`define SWRT_LIM_STEP_MA 100
`endif

// *** tb/swrt_seq_props.sv ***
// concurrent checks on the ports of the sequencer block
// assumes one ref_clk domain and resetn active low
`timescale 1ns/1ps

module swrt_seq_props (
    input logic ref_clk,
    input logic resetn,
    input logic psel,
    input logic penable,
    input logic pready,
    input logic pslverr,
    input logic seq_busy,
    input logic [3:0] current_slot,
    input logic output_pin_a,
    input logic output_pin_b,
    input logic system_domain_up,
    input logic power_domain_up,
    input logic reset_release,
    input logic [12:0] mem_buck_limit,
    input logic [12:0] io_buck_limit,
    input logic [12:0] peripheral_buck_limit,
    input logic [12:0] processor_buck_limit
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // ****************************************
    // bus answer
    // ****************************************
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    ready_cause_a: assert property ($rose(pready) |-> $past(psel & penable))
        else $error("pready without an access");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr outside an answer");

    // ****************************************
    // slot engine
    // ****************************************
    slot_step_a: assert property (!$stable(current_slot) |->
        current_slot == $past(current_slot) + 4'h1 ||
        current_slot == $past(current_slot) - 4'h1)
        else $error("slot pointer jumped");
    slot_idle_a: assert property (
        !seq_busy && !$past(seq_busy) |-> $stable(current_slot))
        else $error("slot moved while idle");
    pin_edge_a: assert property (
        !$stable(output_pin_a) || !$stable(output_pin_b) |-> seq_busy)
        else $error("output pin moved while idle");
    domain_rise_a: assert property (
        $rose(system_domain_up) || $rose(power_domain_up) |-> seq_busy)
        else $error("domain flag rose while idle");
    rel_clear_a: assert property (
        $fell(reset_release) |-> ##[0:2] seq_busy)
        else $error("reset release dropped without a sequence");

    // ****************************************
    // current limit decode
    // ****************************************
    mem_limit_a: assert property ($past(resetn) |->
        mem_buck_limit % 13'd100 == 0 && mem_buck_limit >= 13'd1500 &&
        mem_buck_limit <= 13'd6000)
        else $error("memory limit off grid");
    io_peri_limit_a: assert property ($past(resetn) |->
        io_buck_limit % 13'd100 == 0 && io_buck_limit >= 13'd1500 &&
        io_buck_limit <= 13'd3000 && peripheral_buck_limit >= 13'd1500 &&
        peripheral_buck_limit <= 13'd3000)
        else $error("io or peripheral limit off range");
    proc_limit_a: assert property ($past(resetn) |->
        processor_buck_limit % 13'd100 == 0 &&
        processor_buck_limit >= 13'd500 && processor_buck_limit <= 13'd4000)
        else $error("processor limit off grid");

    release_c: cover property ($rose(reset_release));
    seq_done_c: cover property ($fell(seq_busy));
    bus_err_c: cover property (pslverr);
endmodule // swrt_seq_props

// *** tb/swrt_seq_tb.sv ***
// self-checking bench for the sequencer wait and reset timing block
// assumes the defines header is on the include path
`timescale 1ns/1ps
`include "swrt_seq_defines.vh"

module swrt_seq_tb;
    localparam int TICK = 2;
    localparam int SLOT = 64;
    logic ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic pready, pslverr, erv, gating_input = 0, outside_wakeup = 0;
    logic merge_mode = 0, full_current_mode = 0, reset_output_mode = 0;
    logic output_pin_a, output_pin_b, system_domain_up, power_domain_up;
    logic reset_release, seq_busy;
    logic [3:0] current_slot;
    logic [12:0] mem_buck_limit, io_buck_limit, peripheral_buck_limit;
    logic [12:0] processor_buck_limit;
    logic [7:0] rw_idx[10] = '{8'h82, 8'h90, 8'h91, 8'h92, 8'h95, 8'h96,
        8'h97, 8'h99, 8'h9a, 8'h9b};
    int n_mismatch = 0, num_checks = 0, n;

    always #2.5 ref_clk = ~ref_clk;

    swrt_seq #(.TICK_CYCLES(TICK)) dut (.ref_clk, .resetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .gating_input,
        .outside_wakeup, .merge_mode, .full_current_mode, .reset_output_mode,
        .output_pin_a, .output_pin_b, .system_domain_up, .power_domain_up,
        .reset_release, .seq_busy, .current_slot, .mem_buck_limit,
        .io_buck_limit, .peripheral_buck_limit, .processor_buck_limit);

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] e,
            input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] idx,
            input logic [7:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d);
        chk($sformatf("wr_err %h", idx), 32'h0, {31'h0, erv});
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        xfer(1'b0, idx, 8'h00);
        chk($sformatf("reg %h", idx), {24'h0, e}, rdv);
    endtask

    task automatic wait_idle(input int lim);
        // busy rises on the same edge the start write lands
        @(posedge ref_clk);
        n = 0;
        while (seq_busy !== 1'b0 && n < lim) begin
            @(posedge ref_clk);
            n++;
        end
        chk("seq_busy", 32'h0, {31'h0, seq_busy});
    endtask

    task automatic limits(input int m, input int i, input int p,
            input int r);
        repeat (3) @(posedge ref_clk);
        chk("mem_lim", m, {19'h0, mem_buck_limit});
        chk("io_lim", i, {19'h0, io_buck_limit});
        chk("peri_lim", p, {19'h0, peripheral_buck_limit});
        chk("proc_lim", r, {19'h0, processor_buck_limit});
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        limits(1500, 1500, 1500, 500);
        foreach (rw_idx[i]) rd(rw_idx[i], 8'h00);
        foreach (rw_idx[i]) wr(rw_idx[i], 8'h3c ^ 8'(i));
        foreach (rw_idx[i]) rd(rw_idx[i], 8'h3c ^ 8'(i));
        wr(8'h98, 8'hff);
        rd(8'h98, 8'h00);
        xfer(1'b0, 8'h83, 8'h00);
        chk("unmapped_err", 32'h1, {31'h0, erv});
        wr(8'h81, 8'h07);
        rd(8'h81, 8'h00);
        wr(8'h9a, 8'h3f);
        wr(8'h9b, 8'hf2);
        limits(1800, 3000, 3000, 700);
        merge_mode <= 1'b1;
        full_current_mode <= 1'b1;
        limits(3600, 3000, 3000, 1400);
        // up run with an input gated hold at slot 5
        wr(8'h82, 8'h00);
        wr(8'h90, 8'h12);
        wr(8'h91, 8'h53);
        wr(8'h92, 8'h05);
        wr(8'h95, 8'h64);
        wr(8'h96, 8'h28);
        wr(8'h97, 8'h40);
        wr(8'h99, 8'h41);
        wr(8'ha0, 8'h21);
        repeat (10 * SLOT) @(posedge ref_clk);
        chk("held_slot", 32'h5, {28'h0, current_slot});
        chk("held_busy", 32'h1, {31'h0, seq_busy});
        chk("pin_a_up", 32'h1, {31'h0, output_pin_a});
        chk("pin_b_up", 32'h1, {31'h0, output_pin_b});
        chk("system_domain_up", 32'h1, {31'h0, system_domain_up});
        chk("pwr_early", 32'h0, {31'h0, power_domain_up});
        chk("rel_early", 32'h0, {31'h0, reset_release});
        gating_input <= 1'b1;
        wait_idle(2000);
        chk("final_slot", 32'h8, {28'h0, current_slot});
        chk("power_domain_up", 32'h1, {31'h0, power_domain_up});
        rd(8'h81, 8'h08);
        n = 0;
        while (reset_release !== 1'b1 && n < 3000) begin
            @(posedge ref_clk);
            n++;
        end
        chk("rel_up", 32'h1, {31'h0, reset_release});
        // partial down stops at slot 2
        wr(8'ha0, 8'h06);
        wait_idle(2000);
        chk("part_slot", 32'h2, {28'h0, current_slot});
        chk("pin_a_kept", 32'h1, {31'h0, output_pin_a});
        chk("pin_b_down", 32'h0, {31'h0, output_pin_b});
        chk("sys_down", 32'h0, {31'h0, system_domain_up});
        chk("pwr_down", 32'h0, {31'h0, power_domain_up});
        chk("rel_down", 32'h0, {31'h0, reset_release});
        // full down with a 512 us timer hold at slot 1
        wr(8'h92, 8'h01);
        wr(8'h97, 8'h91);
        wr(8'ha0, 8'h02);
        wait_idle(4000);
        chk("timer_hold", 32'h1, {31'h0, n >= 1150 && n <= 1300});
        chk("zero_slot", 32'h0, {28'h0, current_slot});
        chk("pin_a_down", 32'h0, {31'h0, output_pin_a});
        // wakeup edge starts a 1.024 ms release
        wr(8'h99, 8'h01);
        outside_wakeup <= 1'b1;
        n = 0;
        while (reset_release !== 1'b1 && n < 3000) begin
            @(posedge ref_clk);
            n++;
        end
        chk("rel_wake", 32'h1, {31'h0, reset_release});
        chk("wake_delay", 32'h1, {31'h0, n >= 2040 && n <= 2070});
        results();
    end

    initial begin
        #200000;
        n_mismatch++;
        results();
    end
endmodule // swrt_seq_tb

bind swrt_seq swrt_seq_props u_props (.ref_clk, .resetn, .psel, .penable,
    .pready, .pslverr, .seq_busy, .current_slot, .output_pin_a,
    .output_pin_b, .system_domain_up, .power_domain_up, .reset_release,
    .mem_buck_limit, .io_buck_limit, .peripheral_buck_limit,
    .processor_buck_limit);
